// ---- include/dwscd_pkg.sv ----
// Constants shared by the dual wiper serial command decoder
package dwscd_pkg;

  // ==========================================================================
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int OP_MSB = 23;
  localparam int OP_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int WIPER_W = 10;
  localparam int DATA_W = 16;
  localparam int NV_WORDS = 16;
  localparam int CHANNELS = 2;

  // ==========================================================================
  // Opcodes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RESTORE = 4'h1;
  localparam logic [3:0] OP_SAVE_WIPER = 4'h2;
  localparam logic [3:0] OP_WRITE_STORE = 4'h3;
  localparam logic [3:0] OP_SHR_ONE = 4'h4;
  localparam logic [3:0] OP_SHR_ALL = 4'h5;
  localparam logic [3:0] OP_DEC_ONE = 4'h6;
  localparam logic [3:0] OP_DEC_ALL = 4'h7;
  localparam logic [3:0] OP_RELOAD_ALL = 4'h8;
  localparam logic [3:0] OP_READ_STORE = 4'h9;
  localparam logic [3:0] OP_READ_WIPER = 4'hA;
  localparam logic [3:0] OP_WRITE_WIPER = 4'hB;
  localparam logic [3:0] OP_SHL_ONE = 4'hC;
  localparam logic [3:0] OP_SHL_ALL = 4'hD;
  localparam logic [3:0] OP_INC_ONE = 4'hE;
  localparam logic [3:0] OP_INC_ALL = 4'hF;

  // ==========================================================================
  // Values
  localparam logic [9:0] WIPER_MID = 10'h200;
  localparam logic [9:0] WIPER_MAX = 10'h3FF;
  localparam logic [15:0] NV_WIPER_RESET = 16'h0200;
  localparam logic [15:0] NV_USER_RESET = 16'h0000;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAVE_TIME_MS = 25;
  localparam int SAVE_CYCLES = SAVE_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================================
  // Software port map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_WIPER0 = 8'h08;
  localparam logic [7:0] REG_WIPER1 = 8'h0C;
  localparam int ST_BUSY = 0;
  localparam int ST_READ_PROG = 1;
  localparam int ST_PROTECT = 2;
  localparam int ST_PRESET = 3;
  localparam int CTRL_FRAME_EN = 0;
  localparam logic CTRL_FRAME_EN_RESET = 1'b1;

endpackage : dwscd_pkg

// ---- core/dwscd_top.sv ----
// Serial command decoder driving two wiper registers and a nonvolatile store
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module dwscd_top #(
  parameter int SAVE_CYCLES = dwscd_pkg::SAVE_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic preset_n,
  input wire logic write_protect_n,
  output logic serial_out,
  output logic serial_out_oe,
  output logic ready,
  output logic ready_oe,
  output logic [9:0] wiper0,
  output logic [9:0] wiper1,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // ==========================================================================
  // Input synchronisers
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic [NSYNC-1:0] prev_q;
  assign pin_raw = {write_protect_n, preset_n, serial_in, cs_n, sclk};

  // Reset levels are high for every pin so no false edge after reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {NSYNC{1'b1}};
      sync_q <= {NSYNC{1'b1}};
      prev_q <= {NSYNC{1'b1}};
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic sclk_rise;
  logic cs_low;
  logic cs_rise;
  logic sin_s;
  logic preset_low;
  logic preset_rise;
  logic wp_active;
  assign sclk_rise = sync_q[0] && !prev_q[0];
  assign cs_low = !sync_q[1];
  assign cs_rise = sync_q[1] && !prev_q[1];
  assign sin_s = sync_q[2];
  assign preset_low = !sync_q[3];
  assign preset_rise = sync_q[3] && !prev_q[3];
  assign wp_active = !sync_q[4];

  // ==========================================================================
  // State
  logic [23:0] shift_q;
  logic [9:0] wiper_q [dwscd_pkg::CHANNELS];
  logic [15:0] nv_q [dwscd_pkg::NV_WORDS];
  logic busy_q;
  logic [31:0] save_cnt_q;
  logic read_prog_q;
  logic por_q;
  logic frame_en_q;

  logic exec;
  logic [3:0] op;
  logic [3:0] addr;
  logic [15:0] data;
  assign op = shift_q[dwscd_pkg::OP_MSB:dwscd_pkg::OP_LSB];
  assign addr = shift_q[dwscd_pkg::ADDR_MSB:dwscd_pkg::ADDR_LSB];
  assign data = shift_q[dwscd_pkg::DATA_MSB:0];
  // Frame acted on at chip select rise only, never while a save runs
  assign exec = cs_rise && !busy_q && frame_en_q && !por_q;

  // ==========================================================================
  // Saturating step helpers
  function automatic logic [9:0] shl_sat(input logic [9:0] v);
    if (v == 10'h000) begin
      shl_sat = 10'h001;
    end else if (v >= dwscd_pkg::WIPER_MID) begin
      shl_sat = dwscd_pkg::WIPER_MAX;
    end else begin
      shl_sat = {v[8:0], 1'b0};
    end
  endfunction : shl_sat

  function automatic logic [9:0] inc_sat(input logic [9:0] v);
    inc_sat = (v == dwscd_pkg::WIPER_MAX) ? v : v + 10'h001;
  endfunction : inc_sat

  function automatic logic [9:0] dec_sat(input logic [9:0] v);
    dec_sat = (v == 10'h000) ? v : v - 10'h001;
  endfunction : dec_sat

  // ==========================================================================
  // Power-on refresh: one cycle after reset release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      por_q <= 1'b1;
    end else begin
      por_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Wiper registers
  for (genvar c = 0; c < dwscd_pkg::CHANNELS; c++) begin : g_wiper
    logic hit;
    logic sw_ok;
    assign hit = (addr[0] == 1'(c));
    assign sw_ok = !wp_active;
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        wiper_q[c] <= dwscd_pkg::WIPER_MID;
      end else if (por_q) begin
        wiper_q[c] <= nv_q[c][9:0];
      end else if (preset_low) begin
        wiper_q[c] <= dwscd_pkg::WIPER_MID;
      end else if (preset_rise) begin
        wiper_q[c] <= nv_q[c][9:0];
      end else if (exec) begin
        case (op)
          dwscd_pkg::OP_RESTORE: if (hit) wiper_q[c] <= nv_q[c][9:0];
          dwscd_pkg::OP_RELOAD_ALL: wiper_q[c] <= nv_q[c][9:0];
          dwscd_pkg::OP_SHR_ONE: if (hit && sw_ok) wiper_q[c] <= {1'b0, wiper_q[c][9:1]};
          dwscd_pkg::OP_SHR_ALL: if (sw_ok) wiper_q[c] <= {1'b0, wiper_q[c][9:1]};
          dwscd_pkg::OP_DEC_ONE: if (hit && sw_ok) wiper_q[c] <= dec_sat(wiper_q[c]);
          dwscd_pkg::OP_DEC_ALL: if (sw_ok) wiper_q[c] <= dec_sat(wiper_q[c]);
          dwscd_pkg::OP_WRITE_WIPER: if (hit && sw_ok) wiper_q[c] <= data[9:0];
          dwscd_pkg::OP_SHL_ONE: if (hit && sw_ok) wiper_q[c] <= shl_sat(wiper_q[c]);
          dwscd_pkg::OP_SHL_ALL: if (sw_ok) wiper_q[c] <= shl_sat(wiper_q[c]);
          dwscd_pkg::OP_INC_ONE: if (hit && sw_ok) wiper_q[c] <= inc_sat(wiper_q[c]);
          dwscd_pkg::OP_INC_ALL: if (sw_ok) wiper_q[c] <= inc_sat(wiper_q[c]);
          default: wiper_q[c] <= wiper_q[c];
        endcase
      end
    end
  end

  // ==========================================================================
  // Nonvolatile store; the word changes at once, busy models the write time
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < dwscd_pkg::NV_WORDS; i++) begin
        nv_q[i] <= (i < dwscd_pkg::CHANNELS) ? dwscd_pkg::NV_WIPER_RESET : dwscd_pkg::NV_USER_RESET;
      end
    end else if (exec && op == dwscd_pkg::OP_SAVE_WIPER) begin
      nv_q[addr[0]] <= {6'h00, wiper_q[addr[0]]};
    end else if (exec && op == dwscd_pkg::OP_WRITE_STORE) begin
      nv_q[addr] <= data;
    end
  end

  // ==========================================================================
  // Save timer and ready
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      save_cnt_q <= 32'h0000_0000;
    end else if (exec && (op == dwscd_pkg::OP_SAVE_WIPER || op == dwscd_pkg::OP_WRITE_STORE)) begin
      busy_q <= 1'b1;
      save_cnt_q <= 32'(SAVE_CYCLES - 1);
    end else if (busy_q) begin
      if (save_cnt_q == 32'h0000_0000) begin
        busy_q <= 1'b0;
      end else begin
        save_cnt_q <= save_cnt_q - 32'h0000_0001;
      end
    end
  end

  // Reloads and reads complete in the execute cycle; preset holds ready low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ready <= 1'b1;
      ready_oe <= 1'b0;
    end else begin
      ready <= !(busy_q || preset_low);
      ready_oe <= busy_q || preset_low;
    end
  end

  // ==========================================================================
  // Read-program power state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      read_prog_q <= 1'b0;
    end else if (exec && op == dwscd_pkg::OP_RESTORE) begin
      read_prog_q <= 1'b1;
    end else if (exec && op == dwscd_pkg::OP_NOP) begin
      read_prog_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Serial register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 24'h00_0000;
    end else if (exec && op == dwscd_pkg::OP_READ_STORE) begin
      shift_q[15:0] <= nv_q[addr];
    end else if (exec && op == dwscd_pkg::OP_READ_WIPER) begin
      shift_q[15:0] <= {6'h00, wiper_q[addr[0]]};
    end else if (sclk_rise && cs_low && !busy_q) begin
      shift_q <= {shift_q[22:0], sin_s};
    end
  end

  // Output follows the MSB a few core cycles after each rise; this fits
  // in the high half of a 400 ns serial period but not a much faster one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      serial_out <= 1'b1;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out <= shift_q[23];
      serial_out_oe <= cs_low && !shift_q[23];
    end
  end

  // ==========================================================================
  // Software port
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frame_en_q <= dwscd_pkg::CTRL_FRAME_EN_RESET;
    end else if (reg_wr && reg_addr == dwscd_pkg::REG_CTRL) begin
      frame_en_q <= reg_wdata[dwscd_pkg::CTRL_FRAME_EN];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        dwscd_pkg::REG_STATUS: reg_rdata <= {28'h000_0000, preset_low, wp_active, read_prog_q, busy_q};
        dwscd_pkg::REG_CTRL: reg_rdata <= {31'h0000_0000, frame_en_q};
        dwscd_pkg::REG_WIPER0: reg_rdata <= {22'h00_0000, wiper_q[0]};
        dwscd_pkg::REG_WIPER1: reg_rdata <= {22'h00_0000, wiper_q[1]};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wiper0 <= dwscd_pkg::WIPER_MID;
      wiper1 <= dwscd_pkg::WIPER_MID;
    end else begin
      wiper0 <= wiper_q[0];
      wiper1 <= wiper_q[1];
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic quiet;
  assign quiet = !preset_low && !preset_rise && !por_q;

  sequence s_cmd(logic [3:0] code);
    exec && op == code && quiet;
  endsequence

  sequence s_save_start;
    exec && (op == dwscd_pkg::OP_SAVE_WIPER || op == dwscd_pkg::OP_WRITE_STORE);
  endsequence

  property p_exec_only_at_cs;
    quiet && !exec |=> $stable(wiper_q[0]) && $stable(wiper_q[1]);
  endproperty
  a_exec_only_at_cs: assert property (p_exec_only_at_cs) else $error("wiper moved without a frame end");

  property p_nop;
    s_cmd(dwscd_pkg::OP_NOP) |=> $stable(wiper_q[0]) && $stable(wiper_q[1]) && !read_prog_q;
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");

  property p_restore;
    s_cmd(dwscd_pkg::OP_RESTORE) ##0 (addr[0] == 1'b0) |=> wiper_q[0] == nv_q[0][9:0] && read_prog_q;
  endproperty
  a_restore: assert property (p_restore) else $error("restore failed");

  property p_write_wiper;
    s_cmd(dwscd_pkg::OP_WRITE_WIPER) ##0 (!wp_active && addr[0]) |=> wiper_q[1] == $past(data[9:0]);
  endproperty
  a_write_wiper: assert property (p_write_wiper) else $error("wiper write lost");

  property p_inc_sat;
    s_cmd(dwscd_pkg::OP_INC_ALL) ##0 (!wp_active && wiper_q[0] == dwscd_pkg::WIPER_MAX)
      |=> wiper_q[0] == dwscd_pkg::WIPER_MAX;
  endproperty
  a_inc_sat: assert property (p_inc_sat) else $error("increment passed full scale");

  property p_dec;
    s_cmd(dwscd_pkg::OP_DEC_ALL) ##0 (!wp_active && wiper_q[1] != 10'h000)
      |=> wiper_q[1] == $past(wiper_q[1]) - 10'h001;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  property p_protect;
    s_cmd(dwscd_pkg::OP_SHL_ALL) ##0 wp_active |=> $stable(wiper_q[0]) && $stable(wiper_q[1]);
  endproperty
  a_protect: assert property (p_protect) else $error("protected wiper changed");

  property p_save_busy;
    s_save_start |=> busy_q [*8] ##1 !ready;
  endproperty
  a_save_busy: assert property (p_save_busy) else $error("save did not hold ready low");

  property p_busy_locks;
    busy_q && cs_rise |=> $stable(shift_q);
  endproperty
  a_busy_locks: assert property (p_busy_locks) else $error("frame taken during save");

  property p_read_wiper;
    s_cmd(dwscd_pkg::OP_READ_WIPER) ##0 (addr[0] == 1'b0) |=> shift_q[15:0] == {6'h00, $past(wiper_q[0])};
  endproperty
  a_read_wiper: assert property (p_read_wiper) else $error("readback value wrong");

  property p_preset;
    preset_low && !por_q |=> wiper_q[0] == dwscd_pkg::WIPER_MID && !ready;
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not centre wiper");

endmodule : dwscd_top

// ---- dv/dwscd_host.sv ----
// Host controller model that frames words on the serial link
`timescale 1ns/100ps
module dwscd_host (
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out_oe
);
  logic line;
  // Open-drain output with a pull-up on the board
  assign line = serial_out_oe ? 1'b0 : 1'b1;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // ==========
  // One 24-bit frame; returns what came back on the line
  task automatic xfer(input logic [23:0] w, output logic [23:0] rx);
    // Off the core edge so the two clocks never line up
    #13;
    cs_n = 1'b0;
    #400;
    for (int i = 23; i >= 0; i--) begin
      serial_in = w[i];
      #200;
      rx = {rx[22:0], line};
      sclk = 1'b1;
      #200;
      sclk = 1'b0;
    end
    #200;
    cs_n = 1'b1;
    // Released line must not keep showing the last bit
    serial_in = ~w[0];
  endtask : xfer
endmodule : dwscd_host

// ---- dv/testbench.sv ----
// Self-checking bench for the dual wiper serial command decoder
`timescale 1ns/100ps
module testbench;
  localparam int SAVE_N = 300;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic preset_n = 1'b1;
  logic write_protect_n = 1'b1;
  logic sclk, cs_n, serial_in, serial_out, serial_out_oe, ready, ready_oe;
  logic [9:0] wiper0, wiper1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [23:0] rx;
  int error_cnt = 0;
  int check_count = 0;

  always #25 core_clk = ~core_clk;

  dwscd_top #(.SAVE_CYCLES(SAVE_N)) DUT (.core_clk(core_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .preset_n(preset_n), .write_protect_n(write_protect_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .ready(ready), .ready_oe(ready_oe), .wiper0(wiper0), .wiper1(wiper1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  dwscd_host u_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out_oe(serial_out_oe));

  // ==========
  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic frame(input logic [23:0] w);
    @(posedge core_clk);
    u_host.xfer(w, rx);
    repeat (8) @(posedge core_clk);
    // Look at outputs well after the edge that launched them
    #1;
  endtask : frame

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : reg_read

  task automatic wait_ready();
    int n = 0;
    while (ready !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n > 2000) begin
        error_cnt++;
        wrap_up();
      end
    end
    #1;
  endtask : wait_ready

  // Preload both wipers, run one opcode with junk data bits
  task automatic step(input logic [7:0] oa, input logic [9:0] p0, p1, e0, e1);
    frame({8'hB0, 6'h00, p0});
    frame({8'hB1, 6'h00, p1});
    frame({oa, 16'hFFFF});
    check(wiper0, e0);
    check(wiper1, e1);
  endtask : step

  // ==========
  // ==========
  // Scenarios
  task automatic t_power_on();
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check(wiper0, 10'h200);
    check(wiper1, 10'h200);
  endtask : t_power_on

  task automatic t_write_and_chain();
    @(posedge core_clk);
    u_host.xfer(24'hB0FD55, rx);
    repeat (2) @(posedge core_clk);
    #1;
    check(wiper0, 10'h200);
    repeat (6) @(posedge core_clk);
    #1;
    check(wiper0, 10'h155);
    check(serial_out, 1'b1);
    frame(24'h000000);
    check(rx, 24'hB0FD55);
    check(wiper0, 10'h155);
    check(serial_out, 1'b0);
    check(serial_out_oe, 1'b0);
  endtask : t_write_and_chain

  task automatic t_steps();
    step(8'hE0, 10'h3FE, 10'h005, 10'h3FF, 10'h005);
    step(8'hE1, 10'h005, 10'h3FF, 10'h005, 10'h3FF);
    step(8'h61, 10'h005, 10'h001, 10'h005, 10'h000);
    step(8'h61, 10'h005, 10'h000, 10'h005, 10'h000);
    step(8'h40, 10'h155, 10'h007, 10'h0AA, 10'h007);
    step(8'h41, 10'h155, 10'h000, 10'h155, 10'h000);
    step(8'hC0, 10'h000, 10'h0F3, 10'h001, 10'h0F3);
    step(8'hC1, 10'h000, 10'h200, 10'h000, 10'h3FF);
    step(8'hC1, 10'h000, 10'h0F3, 10'h000, 10'h1E6);
    step(8'hF0, 10'h3FF, 10'h010, 10'h3FF, 10'h011);
    step(8'h70, 10'h000, 10'h010, 10'h000, 10'h00F);
    step(8'h5F, 10'h3FF, 10'h001, 10'h1FF, 10'h000);
    step(8'hD0, 10'h200, 10'h011, 10'h3FF, 10'h022);
  endtask : t_steps

  // Each store write locks the link, so wait before the next word
  task automatic t_store_readback();
    frame(24'h35BEEF);
    wait_ready();
    frame(24'h950000);
    frame(24'h000000);
    check(rx, 24'h95BEEF);
    frame(24'h30FC33);
    wait_ready();
    frame(24'h100000);
    check(wiper0, 10'h033);
    reg_read(dwscd_pkg::REG_STATUS, 32'h2);
    frame(24'h000000);
    reg_read(dwscd_pkg::REG_STATUS, 32'h0);
  endtask : t_store_readback

  task automatic t_save_lock();
    frame(24'hB10123);
    frame(24'h210000);
    check(ready, 1'b0);
    check(ready_oe, 1'b1);
    // Lands entirely inside the save window
    frame(24'hB00377);
    wait_ready();
    check(wiper0, 10'h033);
    frame(24'hB10001);
    check(rx, 24'h210000);
  endtask : t_save_lock

  task automatic t_reload_readback();
    frame(24'h800000);
    check(wiper1, 10'h123);
    check(wiper0, 10'h033);
    frame(24'hA10000);
    frame(24'h000000);
    check(rx, 24'hA10123);
    frame(24'hA00000);
    frame(24'h000000);
    check(rx, 24'hA00033);
  endtask : t_reload_readback

  task automatic t_protect();
    frame(24'hB00100);
    @(posedge core_clk);
    write_protect_n <= 1'b0;
    frame(24'hE10000);
    frame(24'hD00000);
    frame(24'hB00200);
    check(wiper1, 10'h123);
    check(wiper0, 10'h100);
    reg_read(dwscd_pkg::REG_STATUS, 32'h4);
    frame(24'h800000);
    check(wiper0, 10'h033);
    frame(24'h000000);
    @(posedge core_clk);
    write_protect_n <= 1'b1;
  endtask : t_protect

  task automatic t_preset();
    frame(24'hB00100);
    @(posedge core_clk);
    preset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    check(wiper0, 10'h200);
    check(wiper1, 10'h200);
    check(ready_oe, 1'b1);
    @(posedge core_clk);
    preset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    check(wiper0, 10'h033);
    check(wiper1, 10'h123);
    check(ready_oe, 1'b0);
    reg_read(dwscd_pkg::REG_WIPER1, 32'h123);
  endtask : t_preset

  task automatic t_soft_port();
    reg_read(8'h40, 32'h0);
    reg_write(8'h40, 32'hFFFFFFFF);
    reg_read(dwscd_pkg::REG_CTRL, 32'h1);
    reg_write(dwscd_pkg::REG_CTRL, 32'h0);
    reg_read(dwscd_pkg::REG_CTRL, 32'h0);
    // Framing off: words shift through but never execute
    frame(24'hB00155);
    check(wiper0, 10'h033);
    reg_write(dwscd_pkg::REG_CTRL, 32'h1);
    frame(24'hB00155);
    check(wiper0, 10'h155);
  endtask : t_soft_port

  initial begin
    t_power_on();
    t_write_and_chain();
    t_steps();
    t_store_readback();
    t_save_lock();
    t_reload_readback();
    t_protect();
    t_preset();
    t_soft_port();
    wrap_up();
  end
endmodule : testbench
